// ---- design/ldw_dev.sv ----
// device end: dimming mode detection, single-wire receiver, level store
// Notes on behaviour
// - one line carries PWM and serial dimming
// - mode chosen per enable, PWM by default
// - first rising edge enables, starts 1ms window
// - host holds high 100us, then low >260us
// - qualifying low must finish inside window
// - all entry conditions met gives serial mode
// - frames accepted whether or not window has expired
// - mode locked until 2.5ms low shutdown
// - PWM mode gates reference with line level
// - host keeps PWM between 5kHz and 100kHz
// - line is a pure logic input
// - one command selects any of 32 levels
// - level code maps to feedback millivolts
// - level starts at full scale each enable
// - level held in register, reset to full
// - host originates frames, device only acknowledges
// - data used only after address 72 hex
// - data byte: ack flag, subaddress, level
// - acknowledge only for correct frame when requested
// - bit rate adapts from 1.7k to 160k
// - bit7 ack flag, bits6-5 zero, 4-0 level
// - bytes sent most significant bit first
// - acknowledge pulls line low open-drain
`timescale 1ns/1ns
`default_nettype none
module ldw_dev #(
   parameter logic [ldw_pkg::CW-1:0] SHUT_CYC   = ldw_pkg::SHUT_CYC_DEF,
   parameter logic [ldw_pkg::CW-1:0] DELAY_CYC  = ldw_pkg::DELAY_CYC_DEF,
   parameter logic [ldw_pkg::CW-1:0] DETECT_CYC = ldw_pkg::DETECT_CYC_DEF,
   parameter logic [ldw_pkg::CW-1:0] WIN_CYC    = ldw_pkg::WIN_CYC_DEF,
   parameter logic [ldw_pkg::CW-1:0] EOS_CYC    = ldw_pkg::EOS_CYC_DEF,
   parameter logic [ldw_pkg::CW-1:0] ACK_CYC    = ldw_pkg::ACK_CYC_DEF
) (
   input  wire logic                         clk,
   input  wire logic                         rst_b,
   ldw_if.dev                                link,
   output logic                              enabled,
   output logic                              oneWireMode,
   output logic                              pwmGate,
   output logic [ldw_pkg::LEVEL_W-1:0]       levelCode,
   output logic [7:0]                        fbMv,
   output logic                              frameOk
);
   import ldw_pkg::*;

   typedef enum logic [1:0] {MODE_SHUT, MODE_DETECT, MODE_PWM, MODE_ONEWIRE} ldw_mode_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_HIGH, RX_LOW, RX_ACK} ldw_rx_t;

   logic              syncA_q;
   logic              syncB_q;
   logic              prev_q;
   ldw_mode_t         mode_q,     mode_d;
   ldw_rx_t           rx_q,       rx_d;
   logic [CW-1:0]     lowCnt_q,   lowCnt_d;
   logic [CW-1:0]     winCnt_q,   winCnt_d;
   logic [CW-1:0]     phCnt_q,    phCnt_d;
   logic [CW-1:0]     hiLen_q,    hiLen_d;
   logic [CW-1:0]     ackCnt_q,   ackCnt_d;
   logic              lowOk_q,    lowOk_d;
   logic [3:0]        bitCnt_q,   bitCnt_d;
   logic [7:0]        shift_q,    shift_d;
   logic              byteIdx_q,  byteIdx_d;
   logic              addrOk_q,   addrOk_d;
   logic [LEVEL_W-1:0] level_q,   level_d;
   logic              enabled_q,  enabled_d;
   logic              gate_q,     gate_d;
   logic [7:0]        fbMv_q,     fbMv_d;
   logic              frameOk_q,  frameOk_d;
   logic              oe_b_q,     oe_b_d;
   logic              oneWire_q,  oneWire_d;
   logic              lineRise;
   logic              lineFall;
   logic              frameGood;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         // idle level of the pulled-up line, so no false rise follows reset
         syncA_q <= 1'b1;
         syncB_q <= 1'b1;
         prev_q  <= 1'b1;
      end else begin
         syncA_q <= link.line;
         syncB_q <= syncA_q;
         prev_q  <= syncB_q;
      end
   end

   // decisions use only the sampled logic level
   assign lineRise  = syncB_q & ~prev_q;
   assign lineFall  = ~syncB_q & prev_q;
   // address match and zero subaddress make a correct frame
   assign frameGood = addrOk_q & ~shift_q[SUB_HI_BIT] & ~shift_q[SUB_LO_BIT];

   always_comb begin
      mode_d    = mode_q;
      rx_d      = rx_q;
      winCnt_d  = winCnt_q;
      phCnt_d   = (lineRise | lineFall) ? '0 : satInc(phCnt_q);
      hiLen_d   = hiLen_q;
      ackCnt_d  = ackCnt_q;
      lowOk_d   = lowOk_q;
      bitCnt_d  = bitCnt_q;
      shift_d   = shift_q;
      byteIdx_d = byteIdx_q;
      addrOk_d  = addrOk_q;
      level_d   = level_q;
      enabled_d = enabled_q;
      frameOk_d = 1'b0;
      oe_b_d    = 1'b1;
      lowCnt_d  = syncB_q ? '0 : satInc(lowCnt_q);

      case (mode_q)
         MODE_SHUT: begin
            // rising edge enables and opens window
            if (lineRise) begin
               mode_d    = MODE_DETECT;
               enabled_d = 1'b1;
               winCnt_d  = '0;
               lowOk_d   = 1'b0;
               level_d   = LEVEL_FULL;
            end
         end
         MODE_DETECT: begin
            winCnt_d = satInc(winCnt_q);
            // a low counts only if it starts after the hold delay
            if (lineFall) begin
               lowOk_d = (winCnt_q >= DELAY_CYC);
            end
            // the low must exceed detect time within the window
            if (!syncB_q && lowOk_q && (lowCnt_q > DETECT_CYC) && (winCnt_q < WIN_CYC)) begin
               mode_d    = MODE_ONEWIRE;
               rx_d      = RX_IDLE;
               byteIdx_d = 1'b0;
            end else if (winCnt_q >= WIN_CYC) begin
               mode_d = MODE_PWM;
            end
         end
         MODE_PWM: begin
            mode_d = MODE_PWM;
         end
         MODE_ONEWIRE: begin
            // receiver runs regardless of the window
            case (rx_q)
               RX_IDLE: begin
                  if (lineFall) begin
                     rx_d = RX_START;
                  end
               end
               RX_START: begin
                  if (lineRise) begin
                     rx_d     = RX_HIGH;
                     bitCnt_d = '0;
                  end
               end
               RX_HIGH: begin
                  if (lineFall) begin
                     hiLen_d = phCnt_q;
                     rx_d    = RX_LOW;
                  end else if (phCnt_q >= EOS_CYC) begin
                     if (bitCnt_q != BITS_PER_BYTE) begin
                        // short byte: drop the frame
                        rx_d      = RX_IDLE;
                        byteIdx_d = 1'b0;
                     end else if (!byteIdx_q) begin
                        addrOk_d  = (shift_q == DEV_ADDR);
                        byteIdx_d = 1'b1;
                        rx_d      = RX_IDLE;
                     end else begin
                        byteIdx_d = 1'b0;
                        rx_d      = RX_IDLE;
                        if (frameGood) begin
                           // low five bits are the level
                           level_d   = shift_q[LEVEL_W-1:0];
                           frameOk_d = 1'b1;
                           // acknowledge only when asked and correct
                           if (shift_q[ACK_REQ_BIT]) begin
                              rx_d     = RX_ACK;
                              ackCnt_d = '0;
                              oe_b_d   = 1'b0;
                           end
                        end
                     end
                  end
               end
               RX_LOW: begin
                  // bit value is the ratio of high to low time
                  if (lineRise) begin
                     shift_d  = {shift_q[6:0], (hiLen_q > phCnt_q)};
                     bitCnt_d = 4'(bitCnt_q + 1'b1);
                     rx_d     = RX_HIGH;
                  end
               end
               RX_ACK: begin
                  // hold the line low for the acknowledge time
                  ackCnt_d = satInc(ackCnt_q);
                  if (ackCnt_q >= ACK_CYC - 1'b1) begin
                     rx_d = RX_IDLE;
                  end else begin
                     oe_b_d = 1'b0;
                  end
               end
               default: begin
                  rx_d = RX_IDLE;
               end
            endcase
         end
         default: begin
            mode_d = MODE_SHUT;
         end
      endcase

      // long low shuts down and unlocks the mode
      if (mode_q != MODE_SHUT && lowCnt_q >= SHUT_CYC) begin
         mode_d    = MODE_SHUT;
         rx_d      = RX_IDLE;
         enabled_d = 1'b0;
         oe_b_d    = 1'b1;
      end

      // in PWM use the line chops the reference
      gate_d = 1'b0;
      if (mode_d == MODE_DETECT || mode_d == MODE_PWM) begin
         gate_d = syncB_q;
      end else if (mode_d == MODE_ONEWIRE) begin
         gate_d = 1'b1;
      end
      // feedback voltage from the level code
      fbMv_d = enabled_d ? levelToMv(level_d) : 8'h00;
      oneWire_d = (mode_d == MODE_ONEWIRE);
   end

   // level register returns to full scale on reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_q    <= MODE_SHUT;
         rx_q      <= RX_IDLE;
         lowCnt_q  <= '0;
         winCnt_q  <= '0;
         phCnt_q   <= '0;
         hiLen_q   <= '0;
         ackCnt_q  <= '0;
         lowOk_q   <= 1'b0;
         bitCnt_q  <= '0;
         shift_q   <= '0;
         byteIdx_q <= 1'b0;
         addrOk_q  <= 1'b0;
         level_q   <= LEVEL_FULL;
         enabled_q <= 1'b0;
         gate_q    <= 1'b0;
         fbMv_q    <= 8'h00;
         frameOk_q <= 1'b0;
         oe_b_q    <= 1'b1;
         oneWire_q <= 1'b0;
      end else begin
         mode_q    <= mode_d;
         rx_q      <= rx_d;
         lowCnt_q  <= lowCnt_d;
         winCnt_q  <= winCnt_d;
         phCnt_q   <= phCnt_d;
         hiLen_q   <= hiLen_d;
         ackCnt_q  <= ackCnt_d;
         lowOk_q   <= lowOk_d;
         bitCnt_q  <= bitCnt_d;
         shift_q   <= shift_d;
         byteIdx_q <= byteIdx_d;
         addrOk_q  <= addrOk_d;
         level_q   <= level_d;
         enabled_q <= enabled_d;
         gate_q    <= gate_d;
         fbMv_q    <= fbMv_d;
         frameOk_q <= frameOk_d;
         oe_b_q    <= oe_b_d;
         oneWire_q <= oneWire_d;
      end
   end

   // open drain: only ever drives low
   assign link.devOut  = 1'b0;
   assign link.devOe_b = oe_b_q;
   assign enabled      = enabled_q;
   assign oneWireMode  = oneWire_q;
   assign pwmGate      = gate_q;
   assign levelCode    = level_q;
   assign fbMv         = fbMv_q;
   assign frameOk      = frameOk_q;
endmodule
`default_nettype wire

// ---- design/ldw_host.sv ----
// host end: drives shutdown, serial entry, frames and PWM on the line
`timescale 1ns/1ns
`default_nettype none
module ldw_host #(
   parameter logic [ldw_pkg::CW-1:0] SHUTH_CYC = ldw_pkg::SHUTH_CYC_DEF,
   parameter logic [ldw_pkg::CW-1:0] HOLD_CYC  = ldw_pkg::HOLD_CYC_DEF,
   parameter logic [ldw_pkg::CW-1:0] LOWP_CYC  = ldw_pkg::LOWP_CYC_DEF,
   parameter logic [ldw_pkg::CW-1:0] EOSH_CYC  = ldw_pkg::EOSH_CYC_DEF,
   parameter logic [ldw_pkg::CW-1:0] ACKW_CYC  = ldw_pkg::ACKW_CYC_DEF
) (
   input  wire logic                         clk,
   input  wire logic                         rst_b,
   ldw_if.host                               link,
   input  wire logic                         opReq,
   input  wire ldw_pkg::ldw_op_t             opCode,
   input  wire logic [ldw_pkg::LEVEL_W-1:0]  opLevel,
   input  wire logic                         opAckReq,
   input  wire logic                         pwmIn,
   output logic                              busy,
   output logic                              done,
   output logic                              ackSeen
);
   import ldw_pkg::*;

   typedef enum logic [3:0] {H_IDLE, H_PWM, H_SHUT, H_ENHIGH, H_ENLOW, H_START, H_BHI,
                             H_BLO, H_EOS, H_ACK} ldw_hst_t;

   ldw_hst_t      st_q,    st_d;
   logic [CW-1:0] cnt_q,   cnt_d;
   logic [15:0]   frame_q, frame_d;
   logic [3:0]    idx_q,   idx_d;
   logic          out_q,   out_d;
   logic          oe_b_q,  oe_b_d;
   logic          done_q,  done_d;
   logic          ack_q,   ack_d;
   logic          ackHeld_q, ackHeld_d;
   logic [CW-1:0] tgt;
   logic          curBit;

   assign curBit = frame_q[4'hF - idx_q];

   always_comb begin
      case (st_q)
         H_SHUT:   tgt = SHUTH_CYC;
         H_ENHIGH: tgt = HOLD_CYC;
         H_ENLOW:  tgt = LOWP_CYC;
         H_START:  tgt = QBIT_CYC;
         H_BHI:    tgt = curBit ? TQBIT_CYC : QBIT_CYC;
         H_BLO:    tgt = curBit ? QBIT_CYC : TQBIT_CYC;
         H_EOS:    tgt = EOSH_CYC;
         H_ACK:    tgt = ACKW_CYC;
         default:  tgt = '0;
      endcase
   end

   always_comb begin
      st_d    = st_q;
      cnt_d   = satInc(cnt_q);
      frame_d = frame_q;
      idx_d   = idx_q;
      out_d   = out_q;
      oe_b_d  = 1'b0;
      done_d  = 1'b0;
      ack_d   = 1'b0;
      ackHeld_d = ackHeld_q;
      case (st_q)
         H_IDLE, H_PWM: begin
            out_d = (st_q == H_PWM) ? pwmIn : 1'b1;
            if (opReq) begin
               cnt_d = '0;
               case (opCode)
                  OP_SHUTDOWN: begin
                     st_d  = H_SHUT;
                     out_d = 1'b0;
                  end
                  OP_ENTER_OW: begin
                     st_d  = H_ENHIGH;
                     out_d = 1'b1;
                  end
                  OP_SEND: begin
                     // subaddress bits always sent as zero
                     frame_d = {DEV_ADDR, opAckReq, 2'b00, opLevel};
                     idx_d   = '0;
                     st_d    = H_START;
                     out_d   = 1'b0;
                  end
                  OP_PWM: begin
                     st_d   = H_PWM;
                     out_d  = pwmIn;
                     done_d = 1'b1;
                  end
                  default: begin
                     st_d = H_IDLE;
                  end
               endcase
            end
         end
         H_SHUT, H_ENLOW, H_ENHIGH, H_START, H_BHI, H_BLO: begin
            if (cnt_q >= tgt - 1'b1) begin
               cnt_d = '0;
               case (st_q)
                  H_SHUT: begin
                     st_d   = H_IDLE;
                     out_d  = 1'b1;
                     done_d = 1'b1;
                  end
                  H_ENHIGH: begin
                     st_d  = H_ENLOW;
                     out_d = 1'b0;
                  end
                  H_ENLOW: begin
                     st_d   = H_IDLE;
                     out_d  = 1'b1;
                     done_d = 1'b1;
                  end
                  H_START, H_BLO: begin
                     if (st_q == H_BLO) begin
                        idx_d = 4'(idx_q + 1'b1);
                     end
                     st_d  = (st_q == H_BLO && idx_q[2:0] == 3'h7) ? H_EOS : H_BHI;
                     out_d = 1'b1;
                  end
                  default: begin
                     st_d  = H_BLO;
                     out_d = 1'b0;
                  end
               endcase
            end
         end
         H_EOS: begin
            // release for the device's acknowledge instead of fighting it
            oe_b_d = (idx_q == 4'h0) & frame_q[ACK_REQ_BIT];
            ackHeld_d = 1'b0;
            if (cnt_q >= tgt - 1'b1) begin
               cnt_d = '0;
               if (idx_q != 4'h0) begin
                  st_d  = H_START;
                  out_d = 1'b0;
               end else if (frame_q[ACK_REQ_BIT]) begin
                  st_d = H_ACK;
               end else begin
                  st_d   = H_IDLE;
                  done_d = 1'b1;
               end
            end
         end
         H_ACK: begin
            // stay released for the whole window: the device may still be pulling
            oe_b_d    = 1'b1;
            ackHeld_d = ackHeld_q | ~link.line;
            if (cnt_q >= tgt - 1'b1) begin
               ack_d  = ackHeld_d;
               st_d   = H_IDLE;
               done_d = 1'b1;
               out_d  = 1'b1;
            end
         end
         default: begin
            st_d = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q    <= H_IDLE;
         cnt_q   <= '0;
         frame_q <= '0;
         idx_q   <= '0;
         out_q   <= 1'b1;
         oe_b_q  <= 1'b1;
         done_q  <= 1'b0;
         ack_q   <= 1'b0;
         ackHeld_q <= 1'b0;
      end else begin
         st_q    <= st_d;
         cnt_q   <= cnt_d;
         frame_q <= frame_d;
         idx_q   <= idx_d;
         out_q   <= out_d;
         oe_b_q  <= oe_b_d;
         done_q  <= done_d;
         ack_q   <= ack_d;
         ackHeld_q <= ackHeld_d;
      end
   end

   assign link.hostOut  = out_q;
   assign link.hostOe_b = oe_b_q;
   assign busy          = (st_q != H_IDLE) && (st_q != H_PWM);
   assign done          = done_q;
   assign ackSeen       = ack_q;
endmodule
`default_nettype wire

// ---- dv/ldw_line_sva.sv ----
// line-level assertions for the shared dimming control wire
`timescale 1ns/1ns
`default_nettype none
module ldw_line_sva #(
   parameter logic [ldw_pkg::CW-1:0] ACK_CYC = ldw_pkg::ACK_CYC_DEF,
   parameter logic [ldw_pkg::CW-1:0] EOS_CYC = ldw_pkg::EOS_CYC_DEF
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic hostOut,
   input wire logic hostOe_b,
   input wire logic devOut,
   input wire logic devOe_b,
   input wire logic line
);
   import ldw_pkg::*;
   logic [CW-1:0] ackCnt_q, ackCnt_d, hiCnt_q, hiCnt_d;
   // run is far shorter than a counter wrap, so no saturation needed
   always_comb begin
      ackCnt_d = devOe_b ? '0 : ackCnt_q + 1'b1;
      hiCnt_d = line ? hiCnt_q + 1'b1 : '0;
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ackCnt_q <= '0;
         hiCnt_q <= '0;
      end else begin
         ackCnt_q <= ackCnt_d;
         hiCnt_q <= hiCnt_d;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   drain_only_a: assert property (devOut == 1'b0)
      else $error("device drove the line high");
   host_release_a: assert property ($rose(hostOe_b) |-> hostOut)
      else $error("host released the line from a low level");
   ack_bound_a: assert property (ackCnt_q <= ACK_CYC)
      else $error("acknowledge pull too long");
   ack_length_a: assert property (devOe_b && ackCnt_q != '0 |-> ackCnt_q == ACK_CYC)
      else $error("acknowledge pull of wrong length");
   ack_after_eos_a: assert property ($fell(devOe_b) |-> hiCnt_q >= EOS_CYC)
      else $error("acknowledge without end of stream");
   ack_released_a: assert property (!devOe_b |-> hostOe_b)
      else $error("device pulled while host drives");
   dev_quiet_a: assert property ($rose(rst_b) |-> devOe_b)
      else $error("device driving out of reset");
   host_takes_a: assert property ($rose(rst_b) |=> !hostOe_b)
      else $error("host not driving after reset");
   cover property ($fell(devOe_b));
   cover property ($rose(hostOe_b));
   cover property (!line ##1 line);
endmodule
`default_nettype wire

// ---- dv/tb_led_dimming_mode_and_one_wire_rx.sv ----
// self-checking bench: host and device ends joined on one line
`timescale 1ns/1ns
`default_nettype none
module tb_led_dimming_mode_and_one_wire_rx;
   import ldw_pkg::*;
   logic clk, rst_b, opReq, opAckReq, pwmIn, busy, done, ackSeen;
   logic enabled, oneWireMode, pwmGate, frameOk;
   ldw_op_t opCode;
   logic [4:0] opLevel, levelCode, lv;
   logic [7:0] fbMv;
   int n_mismatch, tests_run, seed;
   logic expAck[$];
   logic [4:0] expLv[$];
   ldw_if link();
   // eos shortened but kept above the longest bit half (1875 cycles)
   localparam logic [CW-1:0] T_SHUT = 20'h009C4, T_DELAY = 20'h00064, T_DETECT = 20'h00104;
   localparam logic [CW-1:0] T_WIN = 20'h003E8, T_EOS = 20'h007D0, T_ACK = 20'h00200;
   localparam logic [CW-1:0] T_SHUTH = 20'h00A28, T_HOLD = 20'h00096, T_LOWP = 20'h0012C;
   localparam logic [CW-1:0] T_EOSH = 20'h00834, T_ACKW = 20'h002BC;
   ldw_dev #(.SHUT_CYC(T_SHUT), .DELAY_CYC(T_DELAY), .DETECT_CYC(T_DETECT), .WIN_CYC(T_WIN),
      .EOS_CYC(T_EOS), .ACK_CYC(T_ACK)) ldw_dev_inst (
      .clk(clk), .rst_b(rst_b), .link(link), .enabled(enabled), .oneWireMode(oneWireMode),
      .pwmGate(pwmGate), .levelCode(levelCode), .fbMv(fbMv), .frameOk(frameOk));
   ldw_host #(.SHUTH_CYC(T_SHUTH), .HOLD_CYC(T_HOLD), .LOWP_CYC(T_LOWP), .EOSH_CYC(T_EOSH),
      .ACKW_CYC(T_ACKW)) ldw_host_inst (
      .clk(clk), .rst_b(rst_b), .link(link), .opReq(opReq), .opCode(opCode), .opLevel(opLevel),
      .opAckReq(opAckReq), .pwmIn(pwmIn), .busy(busy), .done(done), .ackSeen(ackSeen));
   ldw_line_sva #(.ACK_CYC(T_ACK), .EOS_CYC(T_EOS)) ldw_line_sva_inst (
      .clk(clk), .rst_b(rst_b), .hostOut(link.hostOut), .hostOe_b(link.hostOe_b),
      .devOut(link.devOut), .devOe_b(link.devOe_b), .line(link.line));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   function automatic logic [7:0] mvOf(input logic [4:0] c);
      if (c == 5'h00) return 8'h00;
      if (c <= 5'h0C) return 8'h02 + 8'h03 * 8'(c);
      if (c <= 5'h17) return 8'h26 + 8'h06 * 8'(c - 5'h0C);
      return 8'h68 + 8'h0C * 8'(c - 5'h17);
   endfunction
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic op(input ldw_op_t c, input logic [4:0] l, input logic a, input int lim);
      int k;
      @(negedge clk);
      opCode = c;
      opLevel = l;
      opAckReq = a;
      opReq = 1'b1;
      @(negedge clk);
      opReq = 1'b0;
      chk("busy", 8'(c != OP_PWM), 8'(busy));
      k = 0;
      while (done !== 1'b1 && k < lim) begin
         @(negedge clk);
         k++;
      end
      if (k >= lim) chk("done", 8'h01, 8'h00);
      @(negedge clk);
   endtask
   // results are matched in order against what the driver noted
   always @(negedge clk) begin
      if (done === 1'b1 && expAck.size() > 0) chk("ackSeen", 8'(expAck.pop_front()), 8'(ackSeen));
      if (frameOk === 1'b1) chk("levelCode", expLv.size() ? 8'(expLv.pop_front()) : 8'hFF, 8'(levelCode));
   end
   initial begin
      #280000;
      n_mismatch++;
      conclude();
   end
   initial begin
      seed = 73317;
      {rst_b, opReq, opAckReq, pwmIn, opLevel, n_mismatch, tests_run} = '0;
      opCode = OP_SHUTDOWN;
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      chk("levelCode", 8'h1F, 8'(levelCode));
      expAck.push_back(1'b0);
      op(OP_SHUTDOWN, 5'h00, 1'b0, 3000);
      chk("enabled", 8'h00, 8'(enabled));
      expAck.push_back(1'b0);
      op(OP_ENTER_OW, 5'h00, 1'b0, 1000);
      chk("oneWireMode", 8'h01, 8'(oneWireMode));
      // frame sent at once, still inside the detection window
      lv = 5'($unsigned($random(seed)) % 31);
      expLv.push_back(lv);
      expAck.push_back(1'b1);
      op(OP_SEND, lv, 1'b1, 60000);
      chk("fbMv", mvOf(lv), fbMv);
      expAck.push_back(1'b0);
      op(OP_SHUTDOWN, 5'h00, 1'b0, 3000);
      chk("enabled", 8'h00, 8'(enabled));
      pwmIn = 1'b1;
      expAck.push_back(1'b0);
      op(OP_PWM, 5'h00, 1'b0, 10);
      // fast random levels never mimic the entry low
      repeat (150) begin
         pwmIn = 1'($random(seed));
         repeat (8) @(negedge clk);
         chk("pwmGate", 8'(pwmIn), 8'(pwmGate));
      end
      chk("oneWireMode", 8'h00, 8'(oneWireMode));
      chk("levelCode", 8'h1F, 8'(levelCode));
      chk("fbMv", 8'hC8, fbMv);
      chk("framesLeft", 8'h00, 8'(expLv.size()));
      conclude();
   end
endmodule
`default_nettype wire

// ---- pkg/ldw_if.sv ----
// shared control line with pull-up, one modport per party
`timescale 1ns/1ns
`default_nettype none
interface ldw_if;
   logic hostOut;
   logic hostOe_b;
   logic devOut;
   logic devOe_b;
   logic line;
   // a released driver leaves the line to the pull-up
   assign line = (hostOe_b | hostOut) & (devOe_b | devOut);
   modport dev  (input line, output devOut, devOe_b);
   modport host (input line, output hostOut, hostOe_b);
endinterface
`default_nettype wire

// ---- pkg/ldw_pkg.sv ----
// shared constants, types and helpers for the dimming line device and host
package ldw_pkg;
   localparam int unsigned CW      = 20;
   localparam int unsigned CLK_MHZ = 250;

   // device timing, microseconds
   localparam int unsigned SHUT_US   = 2500;
   localparam int unsigned DELAY_US  = 100;
   localparam int unsigned DETECT_US = 260;
   localparam int unsigned WIN_US    = 1000;
   localparam int unsigned EOS_US    = 500;
   localparam int unsigned ACK_US    = 512;
   localparam logic [CW-1:0] SHUT_CYC_DEF   = CW'(SHUT_US * CLK_MHZ);
   localparam logic [CW-1:0] DELAY_CYC_DEF  = CW'(DELAY_US * CLK_MHZ);
   localparam logic [CW-1:0] DETECT_CYC_DEF = CW'(DETECT_US * CLK_MHZ);
   localparam logic [CW-1:0] WIN_CYC_DEF    = CW'(WIN_US * CLK_MHZ);
   localparam logic [CW-1:0] EOS_CYC_DEF    = CW'(EOS_US * CLK_MHZ);
   localparam logic [CW-1:0] ACK_CYC_DEF    = CW'(ACK_US * CLK_MHZ);

   // host timing, microseconds; each carries margin over the device figure
   localparam int unsigned BIT_US   = 10;
   localparam int unsigned SHUTH_US = 2600;
   localparam int unsigned HOLD_US  = 150;
   localparam int unsigned LOWP_US  = 300;
   localparam int unsigned EOSH_US  = 520;
   localparam int unsigned ACKW_US  = 600;
   localparam logic [CW-1:0] QBIT_CYC      = CW'(BIT_US * CLK_MHZ / 4);
   localparam logic [CW-1:0] TQBIT_CYC     = CW'(3 * BIT_US * CLK_MHZ / 4);
   localparam logic [CW-1:0] SHUTH_CYC_DEF = CW'(SHUTH_US * CLK_MHZ);
   localparam logic [CW-1:0] HOLD_CYC_DEF  = CW'(HOLD_US * CLK_MHZ);
   localparam logic [CW-1:0] LOWP_CYC_DEF  = CW'(LOWP_US * CLK_MHZ);
   localparam logic [CW-1:0] EOSH_CYC_DEF  = CW'(EOSH_US * CLK_MHZ);
   localparam logic [CW-1:0] ACKW_CYC_DEF  = CW'(ACKW_US * CLK_MHZ);

   // frame layout
   localparam logic [7:0] DEV_ADDR      = 8'h72;
   localparam int unsigned ACK_REQ_BIT  = 7;
   localparam int unsigned SUB_HI_BIT   = 6;
   localparam int unsigned SUB_LO_BIT   = 5;
   localparam int unsigned LEVEL_W      = 5;
   localparam logic [LEVEL_W-1:0] LEVEL_FULL = 5'h1F;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // feedback curve breakpoints
   localparam int unsigned MV_BASE1 = 2;
   localparam int unsigned MV_STEP1 = 3;
   localparam int unsigned LV_KNEE1 = 12;
   localparam int unsigned MV_KNEE1 = 38;
   localparam int unsigned MV_STEP2 = 6;
   localparam int unsigned LV_KNEE2 = 23;
   localparam int unsigned MV_KNEE2 = 104;
   localparam int unsigned MV_STEP3 = 12;

   typedef enum logic [1:0] {OP_SHUTDOWN, OP_ENTER_OW, OP_SEND, OP_PWM} ldw_op_t;

   function automatic logic [CW-1:0] satInc(input logic [CW-1:0] v);
      return (&v) ? v : v + 1'b1;
   endfunction

   function automatic logic [7:0] levelToMv(input logic [LEVEL_W-1:0] lv);
      int unsigned l;
      l = int'(lv);
      if (l == 0) return 8'h00;
      if (l <= LV_KNEE1) return 8'(MV_BASE1 + MV_STEP1 * l);
      if (l <= LV_KNEE2) return 8'(MV_KNEE1 + MV_STEP2 * (l - LV_KNEE1));
      return 8'(MV_KNEE2 + MV_STEP3 * (l - LV_KNEE2));
   endfunction
endpackage
